// ### hw/bitfield_defs.svh
// constants of the bit-field write hazard model
`ifndef BITFIELD_DEFS_SVH
`define BITFIELD_DEFS_SVH
`define RAM_SEL_1K    2'h1
`define RAM_SEL_2K    2'h2
`define RAM_SEL_3K    2'h3
`define RAM_LO_1K     16'hfa00
`define RAM_LO_2K     16'hf600
`define RAM_LO_3K     16'hf200
`define RAM_HI        16'hfdff
`define BITADR_BASE   16'hfd00
`define BITADR_HI     16'hfdff
`define PTR_LO        16'hfce0
`define PTR_HI        16'hfcfe
`define BANK_SPAN     16'h001e
`define STACK_DIST    16'h0020
`define GPR_NIBBLE    4'hf
`define CASEB_MAX     8'hef
`define VL_MAX        8'h7f
`define WORD_MASK     16'hfffe
`define BYTE_ZERO     8'h00
`define RANGE_ZERO    3'h0
`define RANGE_ONE     3'h1
`endif

// ### hw/bitfield_pkg.sv
// types shared by the bit-field write hazard model
package bitfield_pkg;
    // kind of the instruction or transfer in execute, one-hot
    typedef enum logic [5:0] {
        wr_none     = 6'h01, // predecessor that writes no internal ram
        wr_explicit = 6'h02,
        wr_pec      = 6'h04,
        wr_ptr_inc  = 6'h08,
        wr_gpr_inc  = 6'h10,
        wr_stack    = 6'h20
    } write_kind_t;
    typedef enum logic [1:0] {
        st_idle   = 2'h1,
        st_locked = 2'h2
    } lock_state_t;
    typedef struct packed {
        logic [1:0]  ram_size;
        logic [15:0] context_pointer;
        logic [15:0] stack_pointer;
    } cpu_cfg_t;
    typedef struct packed {
        logic        valid;
        write_kind_t kind;
        logic [15:0] addr;
        logic [15:0] data;
        logic        is_byte;
    } exec_op_t;
    typedef struct packed {
        logic        valid;
        logic        is_high;      // bitfield_high_op, else bitfield_low_op
        logic [7:0]  third_byte;   // mask_operand_byte or data_operand_byte
        logic [15:0] operand_value;
        logic [15:0] normal_result;
    } decode_op_t;
    typedef struct packed {
        logic        valid;
        logic        is_byte;
        logic        high_byte;
        logic        is_bitfield;
        logic [15:0] old_value;
        logic [15:0] wdata;
        logic [15:0] prot_mask;
    } sfr_req_t;
    typedef struct packed {
        lock_state_t lock;
        logic [2:0]  lock_count;
        logic        bf_valid;
        logic [15:0] bf_result;
        logic        hazard;
        logic        sfr_valid;
        logic [15:0] sfr_value;
    } model_state_t;
endpackage

// ### hw/bitfield_write_hazard_model.sv
// pipeline model of the bit-field load hazard after an internal ram write
`timescale 1ns/1ns
`include "bitfield_defs.svh"
module bitfield_write_hazard_model (
    input  wire logic                    ref_clk,
    input  wire logic                    resetn,
    input  wire bitfield_pkg::cpu_cfg_t  cfg,
    input  wire bitfield_pkg::exec_op_t  prev_op,
    input  wire bitfield_pkg::decode_op_t bf_op,
    input  wire logic                    prefix_valid,
    input  wire logic [2:0]              prefix_range,
    input  wire logic                    insn_done,
    input  wire bitfield_pkg::sfr_req_t  sfr_req,
    output logic                         bf_result_valid,
    output logic [15:0]                  bf_result,
    output logic                         hazard_hit,
    output logic                         irq_block,
    output logic                         sfr_out_valid,
    output logic [15:0]                  sfr_out_value
);
    bitfield_pkg::model_state_t state_reg;
    bitfield_pkg::model_state_t state_next;

    logic [15:0] ram_lo;
    logic        in_ram;
    logic        is_gpr_sel;
    logic [15:0] gpr_addr;
    logic [15:0] bit_addr;
    logic [15:0] wr_word;
    logic        match_a;
    logic        match_b;
    logic        bank_on_ptrs;
    logic        stack_risky;
    logic        kind_ok;
    logic        fire;
    logic [15:0] prev_result;
    logic [15:0] sfr_placed;

    always_comb
    begin
        case (cfg.ram_size)
            `RAM_SEL_1K: ram_lo = `RAM_LO_1K;
            `RAM_SEL_2K: ram_lo = `RAM_LO_2K;
            default:     ram_lo = `RAM_LO_3K;
        endcase
    end

    assign in_ram       = (prev_op.addr >= ram_lo) && (prev_op.addr <= `RAM_HI);
    assign wr_word      = prev_op.addr & `WORD_MASK; // either byte of a word
    assign is_gpr_sel   = bf_op.third_byte[7:4] == `GPR_NIBBLE;
    assign gpr_addr     = cfg.context_pointer + {11'h000, bf_op.third_byte[3:0], 1'b0};
    assign match_a      = is_gpr_sel && (wr_word == gpr_addr);
    assign bit_addr     = `BITADR_BASE + {7'h00, bf_op.operand_value[7:0], 1'b0};
    assign match_b      = (bf_op.third_byte <= `CASEB_MAX)
                       && (bf_op.operand_value[7:0] <= `VL_MAX)
                       && (wr_word == bit_addr);
    assign bank_on_ptrs = (cfg.context_pointer <= `PTR_HI)
                       && ((cfg.context_pointer + `BANK_SPAN) >= `PTR_LO);
    assign stack_risky  = ((cfg.stack_pointer >= `BITADR_BASE)
                        && (cfg.stack_pointer <= `BITADR_HI))
                       || ((cfg.context_pointer < cfg.stack_pointer)
                        && ((cfg.stack_pointer - cfg.context_pointer) <= `STACK_DIST));

    // pointer increments and stack writes qualify only under their own narrower conditions
    always_comb
    begin
        case (prev_op.kind)
            bitfield_pkg::wr_explicit: kind_ok = match_a || match_b;
            bitfield_pkg::wr_pec:      kind_ok = match_a || match_b;
            bitfield_pkg::wr_gpr_inc:  kind_ok = match_a || match_b;
            bitfield_pkg::wr_ptr_inc:  kind_ok = bank_on_ptrs && match_a;
            bitfield_pkg::wr_stack:    kind_ok = stack_risky && (match_a || match_b);
            bitfield_pkg::wr_none:     kind_ok = 1'b0;
            default:                   kind_ok = 1'b0;
        endcase
    end

    assign fire        = prev_op.valid && bf_op.valid && in_ram && kind_ok;
    assign prev_result = prev_op.is_byte ? {`BYTE_ZERO, prev_op.data[7:0]} : prev_op.data;
    // byte writes land in the addressed half only
    assign sfr_placed  = !sfr_req.is_byte ? sfr_req.wdata
                       : sfr_req.high_byte ? {sfr_req.wdata[7:0], `BYTE_ZERO}
                                           : {`BYTE_ZERO, sfr_req.wdata[7:0]};

    always_comb
    begin
        state_next           = state_reg;
        state_next.bf_valid  = bf_op.valid;
        state_next.hazard    = fire;
        state_next.sfr_valid = sfr_req.valid;
        if (fire)
        begin
            state_next.bf_result = bf_op.normal_result | prev_result;
        end
        else
        begin
            state_next.bf_result = bf_op.normal_result;
        end
        if (sfr_req.valid)
        begin
            if (sfr_req.is_bitfield)
            begin
                state_next.sfr_value = (sfr_placed & ~sfr_req.prot_mask)
                                     | (sfr_req.old_value & sfr_req.prot_mask);
            end
            else
            begin
                state_next.sfr_value = sfr_placed;
            end
        end
        // a new prefix restarts the count; retiring ops use it up
        case (state_reg.lock)
            bitfield_pkg::st_idle:
            begin
                if (prefix_valid && (prefix_range != `RANGE_ZERO))
                begin
                    state_next.lock       = bitfield_pkg::st_locked;
                    state_next.lock_count = prefix_range;
                end
            end
            bitfield_pkg::st_locked:
            begin
                if (prefix_valid && (prefix_range != `RANGE_ZERO))
                begin
                    state_next.lock_count = prefix_range;
                end
                else if (insn_done)
                begin
                    state_next.lock_count = state_reg.lock_count - `RANGE_ONE;
                    if (state_reg.lock_count == `RANGE_ONE)
                    begin
                        state_next.lock = bitfield_pkg::st_idle;
                    end
                end
            end
            default:
            begin
                state_next.lock       = bitfield_pkg::st_idle;
                state_next.lock_count = `RANGE_ZERO;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= '{lock: bitfield_pkg::st_idle, lock_count: 3'h0, bf_valid: 1'b0,
                           bf_result: 16'h0000, hazard: 1'b0, sfr_valid: 1'b0,
                           sfr_value: 16'h0000};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign bf_result_valid = state_reg.bf_valid;
    assign bf_result       = state_reg.bf_result;
    assign hazard_hit      = state_reg.hazard;
    assign irq_block       = state_reg.lock == bitfield_pkg::st_locked;
    assign sfr_out_valid   = state_reg.sfr_valid;
    assign sfr_out_value   = state_reg.sfr_value;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_ram_range;
        hazard_hit |-> $past(prev_op.addr) >= `RAM_LO_3K && $past(prev_op.addr) <= `RAM_HI
            && ($past(cfg.ram_size) != `RAM_SEL_1K || $past(prev_op.addr) >= `RAM_LO_1K)
            && ($past(cfg.ram_size) != `RAM_SEL_2K || $past(prev_op.addr) >= `RAM_LO_2K);
    endproperty
    a_ram_range: assert property (p_ram_range) else $error("hazard outside ram");

    property p_back_to_back;
        hazard_hit |-> $past(prev_op.valid) && $past(bf_op.valid) && bf_result_valid;
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("hazard not paired");

    property p_gpr_match;
        (prev_op.valid && bf_op.valid && prev_op.kind == bitfield_pkg::wr_explicit
         && bf_op.third_byte == 8'hf3 && cfg.ram_size == `RAM_SEL_3K
         && cfg.context_pointer == 16'hfc00 && prev_op.addr == 16'hfc07) |=> hazard_hit;
    endproperty
    a_gpr_match: assert property (p_gpr_match) else $error("register match missed");

    property p_bit_match;
        (prev_op.valid && bf_op.valid && prev_op.kind == bitfield_pkg::wr_explicit
         && bf_op.third_byte == 8'h10 && bf_op.operand_value[7:0] == 8'h05
         && (prev_op.addr | 16'h0001) == 16'hfd0b) |=> hazard_hit;
    endproperty
    a_bit_match: assert property (p_bit_match) else $error("bit area match missed");

    property p_or_result;
        (bf_op.valid && fire && !prev_op.is_byte) |=>
            bf_result == ($past(bf_op.normal_result) | $past(prev_op.data));
    endproperty
    a_or_result: assert property (p_or_result) else $error("corrupted result wrong");

    property p_no_write;
        (prev_op.kind == bitfield_pkg::wr_none) |=> !hazard_hit;
    endproperty
    a_no_write: assert property (p_no_write) else $error("non-writing op fired");

    property p_ptr_needs_gpr;
        (prev_op.kind == bitfield_pkg::wr_ptr_inc && !is_gpr_sel) |=> !hazard_hit;
    endproperty
    a_ptr_needs_gpr: assert property (p_ptr_needs_gpr) else $error("pointer fired");

    property p_stack_safe;
        (prev_op.kind == bitfield_pkg::wr_stack && !stack_risky) |=> !hazard_hit;
    endproperty
    a_stack_safe: assert property (p_stack_safe) else $error("safe stack fired");

    property p_lock_one;
        (!irq_block && prefix_valid && prefix_range == 3'h1) ##1 (insn_done && !prefix_valid)
            |=> !irq_block;
    endproperty
    a_lock_one: assert property (p_lock_one) else $error("one-op lock overran");

    property p_lock_set;
        (prefix_valid && prefix_range != 3'h0) |=> irq_block;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("prefix did not lock");

    property p_byte_clear;
        (sfr_req.valid && sfr_req.is_byte && !sfr_req.is_bitfield && !sfr_req.high_byte)
            |=> sfr_out_valid && sfr_out_value[15:8] == 8'h00;
    endproperty
    a_byte_clear: assert property (p_byte_clear) else $error("other byte kept");

    property p_prot_move;
        (sfr_req.valid && !sfr_req.is_byte && !sfr_req.is_bitfield)
            |=> sfr_out_value == $past(sfr_req.wdata);
    endproperty
    a_prot_move: assert property (p_prot_move) else $error("move kept bits");

    property p_clean;
        (bf_op.valid && !fire) |=> !hazard_hit && bf_result == $past(bf_op.normal_result);
    endproperty
    a_clean: assert property (p_clean) else $error("clean result altered");
endmodule // bitfield_write_hazard_model

// ### verification/bitfield_write_hazard_model_tb_top.sv
// self-checking bench of the bit-field write hazard model
`timescale 1ns/1ns
module bitfield_write_hazard_model_tb_top;
    logic                     ref_clk = 1'b0;
    logic                     resetn = 1'b0;
    bitfield_pkg::cpu_cfg_t   cfg = '0;
    bitfield_pkg::exec_op_t   prev_op = '0;
    bitfield_pkg::decode_op_t bf_op = '0;
    logic                     prefix_valid = 1'b0;
    logic [2:0]               prefix_range = 3'h0;
    logic                     insn_done = 1'b0;
    bitfield_pkg::sfr_req_t   sfr_req = '0;
    logic                     bf_result_valid;
    logic [15:0]              bf_result;
    logic                     hazard_hit;
    logic                     irq_block;
    logic                     sfr_out_valid;
    logic [15:0]              sfr_out_value;
    int                       mismatches = 0;
    int                       n_checks = 0;
    int                       exp_cnt = 0;
    logic [15:0]              exp_sfr = 16'h0000;

    always #5 ref_clk = ~ref_clk;

    bitfield_write_hazard_model i_bitfield_write_hazard_model (
        .ref_clk(ref_clk), .resetn(resetn), .cfg(cfg), .prev_op(prev_op), .bf_op(bf_op),
        .prefix_valid(prefix_valid), .prefix_range(prefix_range), .insn_done(insn_done),
        .sfr_req(sfr_req), .bf_result_valid(bf_result_valid), .bf_result(bf_result),
        .hazard_hit(hazard_hit), .irq_block(irq_block), .sfr_out_valid(sfr_out_valid),
        .sfr_out_value(sfr_out_value)
    );

    task automatic chk1(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s at %0t: got %b", msg, $time, got);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s at %0t: got %h expected %h", msg, $time, got, exp);
        end
    endtask

    function automatic logic [15:0] lo_f(input logic [1:0] s);
        return (s == 2'h1) ? 16'hfa00 : (s == 2'h2) ? 16'hf600 : 16'hf200;
    endfunction

    function automatic logic hit_f();
        logic [15:0] wa;
        logic        a;
        logic        b;
        logic        stk;
        wa = prev_op.addr & 16'hfffe;
        a = bf_op.third_byte[7:4] == 4'hf &&
            wa == cfg.context_pointer + {11'h0, bf_op.third_byte[3:0], 1'b0};
        b = bf_op.third_byte <= 8'hef && bf_op.operand_value[7:0] <= 8'h7f &&
            wa == 16'hfd00 + {7'h0, bf_op.operand_value[7:0], 1'b0};
        stk = (cfg.stack_pointer >= 16'hfd00 && cfg.stack_pointer <= 16'hfdff) ||
              (cfg.context_pointer < cfg.stack_pointer &&
               cfg.stack_pointer - cfg.context_pointer <= 16'h0020);
        if (!(prev_op.valid && bf_op.valid && prev_op.addr >= lo_f(cfg.ram_size) &&
              prev_op.addr <= 16'hfdff))
            return 1'b0;
        case (prev_op.kind)
            bitfield_pkg::wr_none: return 1'b0;
            bitfield_pkg::wr_ptr_inc: return a && cfg.context_pointer <= 16'hfcfe &&
                                      cfg.context_pointer + 16'h001e >= 16'hfce0;
            bitfield_pkg::wr_stack: return (a || b) && stk;
            default: return a || b;
        endcase
    endfunction

    // expectations are taken before the edge, outputs looked at 1 ns after it
    task automatic step();
        logic        h;
        logic        v;
        logic [15:0] r;
        logic [15:0] p;
        h = hit_f();
        v = bf_op.valid;
        r = bf_op.normal_result;
        if (h)
            r = r | (prev_op.is_byte ? {8'h00, prev_op.data[7:0]} : prev_op.data);
        if (prefix_valid && prefix_range != 3'h0)
            exp_cnt = prefix_range;
        else if (exp_cnt != 0 && insn_done)
            exp_cnt--;
        p = sfr_req.high_byte ? {sfr_req.wdata[7:0], 8'h00} : {8'h00, sfr_req.wdata[7:0]};
        if (!sfr_req.is_byte)
            p = sfr_req.wdata;
        if (sfr_req.is_bitfield)
            p = (sfr_req.old_value & sfr_req.prot_mask) | (p & ~sfr_req.prot_mask);
        if (sfr_req.valid)
            exp_sfr = p;
        @(posedge ref_clk);
        #1;
        chk1(bf_result_valid, v, "result valid");
        chk1(hazard_hit, h, "hazard flag");
        if (v)
            chk16(bf_result, r, "bit-field result");
        chk1(irq_block, exp_cnt != 0, "interrupt block");
        chk1(sfr_out_valid, sfr_req.valid, "sfr valid");
        chk16(sfr_out_value, exp_sfr, "sfr value");
    endtask

    task automatic go(input logic [5:0] k, input logic [15:0] a, input logic [15:0] d,
                      input logic by, input logic [7:0] t, input logic [15:0] v, input logic en);
        prev_op = '{1'b1, bitfield_pkg::write_kind_t'(k), a, d, by};
        bf_op = '{en, 1'($urandom), t, v, 16'($urandom)};
        step();
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #100000;
        mismatches++;
        end_of_test();
    end

    initial
    begin
        logic [15:0] cp;
        logic [15:0] v;
        logic [7:0]  t;
        int          sel;
        void'($urandom(32'he857));
        repeat (3) @(posedge ref_clk);
        #1;
        chk1(bf_result_valid | hazard_hit | irq_block | sfr_out_valid, 1'b0, "reset");
        resetn = 1'b1;
        step();
        cfg = '{2'h3, 16'hfc00, 16'hfa00};
        go(6'h02, 16'hfc07, 16'h0012, 1'b0, 8'hf3, 16'h0000, 1'b1);
        go(6'h02, 16'hfc07, 16'h0012, 1'b0, 8'hf3, 16'h0000, 1'b0);
        for (int s = 1; s < 4; s++)
        begin
            cfg = '{2'(s), lo_f(2'(s)) - 16'h0002, 16'h0000};
            go(6'h02, cfg.context_pointer, 16'h8001, 1'b0, 8'hf0, 16'h0000, 1'b1);
            cfg.context_pointer = lo_f(2'(s));
            go(6'h04, cfg.context_pointer, 16'h0081, 1'b1, 8'hf0, 16'h0000, 1'b1);
        end
        cfg = '{2'h3, 16'hfce0, 16'hfd00};
        for (int k = 0; k < 6; k++)
        begin
            go(6'h01 << k, 16'hfce4, 16'h4000, 1'b0, 8'hf2, 16'h0000, 1'b1);
            go(6'h01 << k, 16'hfd0b, 16'h0033, 1'b1, 8'h10, 16'h0005, 1'b1);
        end
        cfg = '{2'h3, 16'hfc00, 16'hfc20};
        go(6'h20, 16'hfc01, 16'h00a5, 1'b1, 8'hf0, 16'h0000, 1'b1);
        go(6'h08, 16'hfc00, 16'h00a5, 1'b0, 8'hf0, 16'h0000, 1'b1);
        cfg = '{2'h3, 16'hf400, 16'hfc22};
        go(6'h20, 16'hf400, 16'h00a5, 1'b0, 8'hf0, 16'h0000, 1'b1);
        go(6'h02, 16'hfdfe, 16'h1000, 1'b0, 8'hef, 16'h127f, 1'b1);
        go(6'h02, 16'hfd00, 16'h1000, 1'b0, 8'hef, 16'h1280, 1'b1);
        go(6'h02, 16'hfdfe, 16'h1000, 1'b0, 8'hf0, 16'h007f, 1'b1);
        // one-op prefix before a bit-field op, then a range-4 prefix restarted by a range-3 prefix two ops later
        insn_done = 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            prefix_valid = c == 0 || c == 2 || c == 4;
            prefix_range = c == 0 ? 3'h1 : c == 2 ? 3'h4 : 3'h3;
            go(6'h02, 16'hf400, 16'h0001, 1'b0, 8'hf0, 16'h0000, c == 1 || c == 5);
        end
        // reset in mid-run while a prefix range is open
        prefix_valid = 1'b1;
        step();
        prefix_valid = 1'b0;
        resetn = 1'b0;
        exp_cnt = 0;
        exp_sfr = 16'h0000;
        @(posedge ref_clk);
        #1;
        chk1(bf_result_valid | hazard_hit | irq_block | sfr_out_valid, 1'b0, "reset");
        chk16(bf_result | sfr_out_value, 16'h0000, "reset value");
        resetn = 1'b1;
        step();
        // random mix biased towards matching addresses so hits are frequent
        for (int i = 0; i < 2000; i++)
        begin
            cp = 16'hfbe0 + 16'(($urandom % 10) * 32);
            cfg = '{2'($urandom), cp, ($urandom % 2) ? 16'hfd40 : 16'hfc10};
            t = ($urandom % 2) ? {4'hf, 4'($urandom)} : 8'($urandom);
            v = 16'($urandom);
            sel = $urandom % 3;
            prefix_valid = ($urandom % 6) == 0;
            prefix_range = 3'($urandom % 5);
            if (exp_cnt != 0 && prefix_range == 3'h0)
                prefix_range = 3'h1;
            insn_done = 1'($urandom);
            sfr_req = '{1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
                        16'($urandom), 16'($urandom), 16'($urandom)};
            go(6'h01 << ($urandom % 6),
               sel == 0 ? cp + {11'h0, t[3:0], 1'b0} :
               sel == 1 ? 16'hfd00 + {7'h0, v[7:0], 1'b0} : 16'hf200 + 16'($urandom % 3072),
               16'($urandom), 1'($urandom), t, v, ($urandom % 4) != 0);
        end
        end_of_test();
    end
endmodule // bitfield_write_hazard_model_tb_top
